// >>> sscc_pkg.sv
package sscc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_H_SEL      = 6'h12;
  localparam logic [5:0] IDX_H_WIDTH    = 6'h13;
  localparam logic [5:0] IDX_V_SEL      = 6'h14;
  localparam logic [5:0] IDX_V_WIDTH    = 6'h15;
  localparam logic [5:0] IDX_COAST_LEAD = 6'h16;
  localparam logic [5:0] IDX_COAST_TRL  = 6'h17;
  localparam logic [5:0] IDX_COAST_SEL  = 6'h18;
  localparam logic [5:0] IDX_STATUS     = 6'h1F;
  localparam int         NREG           = 7;
  localparam int         ADDR_W         = 8;
  localparam int         IDX_LSB        = 2;

  // Bit positions in the select and polarity registers
  localparam int B_SRC_OVR  = 7;
  localparam int B_SRC_SEL  = 6;
  localparam int B_POL_OVR  = 5;
  localparam int B_POL_USR  = 4;
  localparam int B_OUT_POL  = 3;
  localparam int B_V_FILT   = 2;
  localparam int B_V_DUR_EN = 1;
  localparam int B_C_SRC    = 7;
  localparam int B_C_OVR    = 6;
  localparam int B_C_POL    = 5;

  // Reset values
  localparam logic [7:0] RST_H_SEL      = 8'h18;
  localparam logic [7:0] RST_H_WIDTH    = 8'h00;
  localparam logic [7:0] RST_V_SEL      = 8'h18;
  localparam logic [7:0] RST_V_WIDTH    = 8'h0A;
  localparam logic [7:0] RST_COAST_LEAD = 8'h00;
  localparam logic [7:0] RST_COAST_TRL  = 8'h00;
  localparam logic [7:0] RST_COAST_SEL  = 8'h20;

  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int SYNC_LOSS_US   = 50000;
  localparam int LOSS_CYCLES    = SYNC_LOSS_US * CLK_MHZ;
  localparam int ACT_W          = 20;
  localparam int POL_W          = 12;
  localparam int LINE_W         = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> sscc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Hsync input polarity auto-detected unless override bit set; override resets 0.
// - With override, user bit 0 means active low, 1 active high; resets 1.
// - Hsync output active low for polarity bit 0, high for 1; resets 1.
// - Hsync output starts on feedback clock, lasts programmed pixel clocks.
// - Vsync source chosen automatically unless override bit set; resets 0.
// - Overridden vsync source: 0 input pin, 1 sync separator; resets 0.
// - Vsync input polarity auto-detected unless override bit set; resets 0.
// - With override, vsync user bit 0 active low, 1 active high; resets 1.
// - Vsync output negative for polarity bit 0, positive for 1; resets 1.
// - Vsync filter aligns vsync to hsync when enabled, bypassed otherwise.
// - Vsync duration enable 0 keeps width; 1 uses duration register.
// - Vsync duration value used only when enabled; resets to ten.
// - Internal coast starts programmed hsync periods before vsync; resets zero.
// - Internal coast held programmed hsync periods after vsync ends.
// - Coast source 0 derives coast from vsync; 1 uses coast pin.
// - Coast polarity determined internally unless override bit set; resets 0.
// - User coast polarity applied only under override; resets 1.
// - User coast polarity 0 means negative, 1 means positive.
// - Hsync source chosen automatically unless override bit set; resets 0.
// - User or dual-active hsync source: 0 input pin, 1 green sync.
module sscc_top #(
  parameter int unsigned ACT_LIMIT = sscc_pkg::LOSS_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic [sscc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [sscc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        hsync_pin,
  input  wire logic                        green_embedded_sync,
  input  wire logic                        vsync_pin,
  input  wire logic                        sep_vsync,
  input  wire logic                        coast_pin,
  input  wire logic                        pll_feedback,
  output logic                             hsync_out,
  output logic                             vsync_out,
  output logic                             pll_coast
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin index in the synchroniser vectors
  localparam int P_H = 0;
  localparam int P_G = 1;
  localparam int P_V = 2;
  localparam int P_S = 3;
  localparam int P_C = 4;
  localparam int P_F = 5;
  localparam int NPIN = 6;
  localparam logic [sscc_pkg::ACT_W-1:0] ACT_MAX =
    sscc_pkg::ACT_W'(ACT_LIMIT);
  localparam logic [sscc_pkg::POL_W-1:0] POL_MAX = '1;

  typedef struct packed {
    logic [sscc_pkg::NREG-1:0][7:0]               cfg;
    logic [NPIN-1:0]                              s1;
    logic [NPIN-1:0]                              s2;
    logic [NPIN-1:0]                              sp;
    logic [3:0][sscc_pkg::ACT_W-1:0]              act;
    logic [2:0][sscc_pkg::POL_W-1:0]              hi;
    logic [2:0][sscc_pkg::POL_W-1:0]              lo;
    logic [2:0]                                   det;
    logic [2:0]                                   dprev;
    logic                                         h_prev;
    logic [7:0]                                   hs_cnt;
    logic                                         hs_on;
    logic                                         vs_f;
    logic                                         vs_fprev;
    logic                                         vpulse;
    logic [7:0]                                   vdur;
    logic [sscc_pkg::LINE_W-1:0]                  line;
    logic [sscc_pkg::LINE_W-1:0]                  frame;
    logic [7:0]                                   post;
    logic                                         hs_o;
    logic                                         vs_o;
    logic                                         co_o;
    logic                                         aw_ok;
    logic [sscc_pkg::ADDR_W-1:0]                  awaddr;
    logic                                         w_ok;
    logic [7:0]                                   wdata;
    logic                                         wlane;
    logic                                         bvalid;
    logic [1:0]                                   bresp;
    logic                                         rvalid;
    logic [31:0]                                  rdata;
    logic [1:0]                                   rresp;
  } sscc_state_t;

  sscc_state_t q;
  sscc_state_t next_q;

  // Maps a byte address onto a configuration slot; NREG means unmapped
  function automatic int unsigned sscc_slot(
    input logic [sscc_pkg::ADDR_W-1:0] a
  );
    logic [5:0] idx;
    idx = a[sscc_pkg::ADDR_W-1:sscc_pkg::IDX_LSB];
    if (a[sscc_pkg::IDX_LSB-1:0] != '0) begin
      return sscc_pkg::NREG;
    end else if (idx >= sscc_pkg::IDX_H_SEL &&
                 idx <= sscc_pkg::IDX_COAST_SEL) begin
      return 32'(idx - sscc_pkg::IDX_H_SEL);
    end else begin
      return sscc_pkg::NREG;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source and polarity selection
  logic [7:0] r_h;
  logic [7:0] r_v;
  logic [7:0] r_c;
  logic [3:0] alive;
  logic       h_green;
  logic       v_sep;
  logic       h_pol;
  logic       v_pol;
  logic       c_pol;
  logic       h_raw;
  logic       v_raw;
  logic       h_n;
  logic       v_n;
  logic       c_ext;
  logic       h_lead;
  logic       c_int;
  logic       lead_hit;
  logic       vs_shape;
  logic [sscc_pkg::LINE_W:0] lead_sum;

  assign r_h = q.cfg[sscc_pkg::IDX_H_SEL - sscc_pkg::IDX_H_SEL];
  assign r_v = q.cfg[sscc_pkg::IDX_V_SEL - sscc_pkg::IDX_H_SEL];
  assign r_c = q.cfg[sscc_pkg::IDX_COAST_SEL - sscc_pkg::IDX_H_SEL];

  for (genvar i = 0; i < 4; i++) begin : g_alive
    assign alive[i] = q.act[i] < ACT_MAX;
  end

  always_comb begin
    // Dual-active hsync defers to the select bit as well
    if (r_h[sscc_pkg::B_SRC_OVR] || (alive[P_H] && alive[P_G])) begin
      h_green = r_h[sscc_pkg::B_SRC_SEL];
    end else begin
      h_green = !alive[P_H] && alive[P_G];
    end
    if (r_v[sscc_pkg::B_SRC_OVR]) begin
      v_sep = r_v[sscc_pkg::B_SRC_SEL];
    end else begin
      v_sep = !alive[P_V] && alive[P_S];
    end
  end

  assign h_pol = r_h[sscc_pkg::B_POL_OVR] ? r_h[sscc_pkg::B_POL_USR]
                                          : q.det[0];
  assign v_pol = r_v[sscc_pkg::B_POL_OVR] ? r_v[sscc_pkg::B_POL_USR]
                                          : q.det[1];
  assign c_pol = r_c[sscc_pkg::B_C_OVR] ? r_c[sscc_pkg::B_C_POL]
                                        : q.det[2];
  assign h_raw = h_green ? q.s2[P_G] : q.s2[P_H];
  assign v_raw = v_sep ? q.s2[P_S] : q.s2[P_V];
  assign h_n = h_pol ? h_raw : !h_raw;
  assign v_n = v_pol ? v_raw : !v_raw;
  assign c_ext = c_pol ? q.s2[P_C] : !q.s2[P_C];
  assign h_lead = h_n && !q.h_prev;

  // Lead window opens once the remaining lines drop to the lead count
  assign lead_sum = {1'b0, q.line} +
                    (sscc_pkg::LINE_W+1)'(q.cfg[sscc_pkg::IDX_COAST_LEAD -
                                                sscc_pkg::IDX_H_SEL]);
  assign lead_hit = (q.cfg[sscc_pkg::IDX_COAST_LEAD - sscc_pkg::IDX_H_SEL]
                     != 8'h00) && (q.frame != '0) &&
                    (lead_sum >= {1'b0, q.frame});
  assign c_int = q.vs_f || lead_hit || (q.post != 8'h00);
  assign vs_shape = r_v[sscc_pkg::B_V_DUR_EN] ? q.vpulse : q.vs_f;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [2:0] din;
    int unsigned slot;
    din = {q.s2[P_C], v_raw, h_raw};
    slot = 0;
    next_q = q;
    next_q.s1 = {pll_feedback, coast_pin, sep_vsync, vsync_pin,
                 green_embedded_sync, hsync_pin};
    next_q.s2 = q.s1;
    next_q.sp = q.s2;

    // A source is alive while it keeps toggling within the loss time
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] != q.sp[i]) begin
        next_q.act[i] = '0;
      end else if (alive[i]) begin
        next_q.act[i] = q.act[i] + 1'b1;
      end
    end

    // Compare level times once per period, at each rising edge
    for (int i = 0; i < 3; i++) begin
      next_q.dprev[i] = din[i];
      if (din[i] && !q.dprev[i]) begin
        next_q.det[i] = q.hi[i] < q.lo[i];
        next_q.hi[i] = '0;
        next_q.lo[i] = '0;
      end else if (din[i] && q.hi[i] != POL_MAX) begin
        next_q.hi[i] = q.hi[i] + 1'b1;
      end else if (!din[i] && q.lo[i] != POL_MAX) begin
        next_q.lo[i] = q.lo[i] + 1'b1;
      end
    end

    // Hsync output pulse from the phase-adjusted feedback edge
    next_q.h_prev = h_n;
    if (q.s2[P_F] && !q.sp[P_F]) begin
      next_q.hs_cnt = q.cfg[sscc_pkg::IDX_H_WIDTH - sscc_pkg::IDX_H_SEL];
      next_q.hs_on = q.cfg[sscc_pkg::IDX_H_WIDTH - sscc_pkg::IDX_H_SEL]
                     != 8'h00;
    end else if (q.hs_on) begin
      next_q.hs_cnt = q.hs_cnt - 1'b1;
      next_q.hs_on = q.hs_cnt != 8'h01;
    end
    next_q.hs_o = next_q.hs_on == r_h[sscc_pkg::B_OUT_POL];

    // With the filter enabled, filtered vsync only moves on an hsync leading edge
    next_q.vs_fprev = q.vs_f;
    if (!r_v[sscc_pkg::B_V_FILT] || h_lead) begin
      next_q.vs_f = v_n;
    end

    // Duration block counts lines from the vsync leading edge; it starts
    // with the filtered vsync itself so the width is whole lines
    if (next_q.vs_f && !q.vs_f) begin
      next_q.vdur = q.cfg[sscc_pkg::IDX_V_WIDTH - sscc_pkg::IDX_H_SEL];
      next_q.vpulse = q.cfg[sscc_pkg::IDX_V_WIDTH - sscc_pkg::IDX_H_SEL]
                      != 8'h00;
    end else if (q.vpulse && h_lead) begin
      next_q.vdur = q.vdur - 1'b1;
      next_q.vpulse = q.vdur != 8'h01;
    end
    next_q.vs_o = vs_shape == r_v[sscc_pkg::B_OUT_POL];

    // Line counting for the coast lead; frame length learnt last frame
    if (q.vs_f && !q.vs_fprev) begin
      next_q.frame = q.line;
      next_q.line = '0;
    end else if (h_lead) begin
      next_q.line = q.line + 1'b1;
    end
    if (!next_q.vs_f && q.vs_f) begin
      next_q.post = q.cfg[sscc_pkg::IDX_COAST_TRL -
                          sscc_pkg::IDX_H_SEL];
    end else if (h_lead && q.post != 8'h00) begin
      next_q.post = q.post - 1'b1;
    end
    next_q.co_o = r_c[sscc_pkg::B_C_SRC] ? c_ext : c_int;

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_ok = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_ok = 1'b1;
      next_q.wdata = s_axi_wdata[7:0];
      next_q.wlane = s_axi_wstrb[0];
    end
    if (q.aw_ok && q.w_ok) begin
      slot = sscc_slot(q.awaddr);
      next_q.aw_ok = 1'b0;
      next_q.w_ok = 1'b0;
      next_q.bvalid = 1'b1;
      if (slot < sscc_pkg::NREG) begin
        next_q.bresp = sscc_pkg::RESP_OKAY;
        if (q.wlane) begin
          next_q.cfg[slot] = q.wdata;
        end
      end else if (q.awaddr[sscc_pkg::ADDR_W-1:sscc_pkg::IDX_LSB] ==
                   sscc_pkg::IDX_STATUS) begin
        next_q.bresp = sscc_pkg::RESP_OKAY;
      end else begin
        next_q.bresp = sscc_pkg::RESP_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      slot = sscc_slot(s_axi_araddr);
      next_q.rvalid = 1'b1;
      next_q.rresp = sscc_pkg::RESP_OKAY;
      next_q.rdata = 32'h0000_0000;
      if (slot < sscc_pkg::NREG) begin
        next_q.rdata[7:0] = q.cfg[slot];
      end else if (s_axi_araddr[sscc_pkg::ADDR_W-1:sscc_pkg::IDX_LSB] ==
                   sscc_pkg::IDX_STATUS &&
                   s_axi_araddr[sscc_pkg::IDX_LSB-1:0] == '0) begin
        next_q.rdata[7:0] = {alive[P_V], alive[P_G], alive[P_H], v_sep,
                             h_green, q.det};
      end else begin
        next_q.rresp = sscc_pkg::RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; clock enable low freezes everything, bus included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cfg[0] <= sscc_pkg::RST_H_SEL;
      q.cfg[1] <= sscc_pkg::RST_H_WIDTH;
      q.cfg[2] <= sscc_pkg::RST_V_SEL;
      q.cfg[3] <= sscc_pkg::RST_V_WIDTH;
      q.cfg[4] <= sscc_pkg::RST_COAST_LEAD;
      q.cfg[5] <= sscc_pkg::RST_COAST_TRL;
      q.cfg[6] <= sscc_pkg::RST_COAST_SEL;
      q.det <= 3'h7;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // Readies drop with the clock enable so no beat is lost while frozen
  assign s_axi_awready = ce && !q.aw_ok && !q.bvalid;
  assign s_axi_wready  = ce && !q.w_ok && !q.bvalid;
  assign s_axi_arready = ce && !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign hsync_out     = q.hs_o;
  assign vsync_out     = q.vs_o;
  assign pll_coast     = q.co_o;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_h_pol;
    r_h[sscc_pkg::B_POL_OVR] |-> h_pol == r_h[sscc_pkg::B_POL_USR];
  endproperty
  a_h_pol: assert property (p_h_pol) else $error("hsync polarity");

  property p_hs_width;
    ce && q.s2[P_F] && !q.sp[P_F] &&
    q.cfg[1] == 8'h05 ##1 ce[*5] |->
      (q.hs_on && $past(q.hs_on, 4)) ##1 !q.hs_on;
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("hsync width");

  property p_hs_out;
    ce |=> hsync_out == (q.hs_on == $past(r_h[sscc_pkg::B_OUT_POL]));
  endproperty
  a_hs_out: assert property (p_hs_out) else $error("hsync out pol");

  property p_v_src;
    r_v[sscc_pkg::B_SRC_OVR] |-> v_sep == r_v[sscc_pkg::B_SRC_SEL];
  endproperty
  a_v_src: assert property (p_v_src) else $error("vsync source");

  property p_h_src;
    r_h[sscc_pkg::B_SRC_OVR] |-> h_green == r_h[sscc_pkg::B_SRC_SEL];
  endproperty
  a_h_src: assert property (p_h_src) else $error("hsync source");

  property p_v_bypass;
    ce && !r_v[sscc_pkg::B_V_FILT] |=> q.vs_f == $past(v_n);
  endproperty
  a_v_bypass: assert property (p_v_bypass) else $error("vsync filter");

  property p_post;
    ce && q.vs_f && !next_q.vs_f |=> q.post == $past(q.cfg[5]);
  endproperty
  a_post: assert property (p_post) else $error("coast trail");

  property p_c_src;
    ce && r_c[sscc_pkg::B_C_SRC] |=> pll_coast == $past(c_ext);
  endproperty
  a_c_src: assert property (p_c_src) else $error("coast source");

  property p_lead;
    ce && !r_c[sscc_pkg::B_C_SRC] && lead_hit |=> pll_coast;
  endproperty
  a_lead: assert property (p_lead) else $error("coast lead");

  c_hs: cover property (q.hs_on ##1 !q.hs_on);
  c_vp: cover property (q.vpulse ##1 !q.vpulse);
  c_co: cover property (lead_hit ##1 q.vs_f);
endmodule

// >>> sscc_video_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Analog source model: free-running lines and frames on the pixel clock
module sscc_video_src #(
  parameter int LINE  = 40,
  parameter int HW    = 4,
  parameter int LINES = 12,
  parameter int VW    = 2
) (
  input  wire logic aclk,
  input  wire logic h_pol,
  input  wire logic v_pol,
  input  wire logic coast_lvl,
  output logic      hsync_pin,
  output logic      green_embedded_sync,
  output logic      vsync_pin,
  output logic      sep_vsync,
  output logic      coast_pin,
  output logic      pll_feedback
);
  int px = 0;
  int ln = 0;
  always_ff @(posedge aclk) begin
    px <= (px == LINE - 1) ? 0 : px + 1;
    if (px == LINE - 1) begin
      ln <= (ln == LINES - 1) ? 0 : ln + 1;
    end
  end
  // Vsync edges land on hsync leading edges, so filtering keeps the width
  assign hsync_pin           = (px < HW) ~^ h_pol;
  assign vsync_pin           = (ln < VW) ~^ v_pol;
  // No composite or green sync here: both stay quiet
  assign green_embedded_sync = 1'b0;
  assign sep_vsync           = 1'b0;
  assign coast_pin           = coast_lvl;
  assign pll_feedback        = px < LINE / 2;
endmodule

// >>> test_sync_select_coast_control.sv
`timescale 1ns/1ps
module test_sync_select_coast_control;
  localparam int LINE  = 40;
  localparam int LINES = 12;
  localparam int VW    = 2;
  localparam int FRAME = LINE * LINES;
  localparam int LIMIT = 60000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic [3:0]  wstrb = 4'hF;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        hs, gs, vs, sv, cp, fb, hsync_out, vsync_out, pll_coast;
  logic        h_pol = 1'b1;
  logic        v_pol = 1'b1;
  logic        coast_lvl = 1'b0;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          nh, nv, nc;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  rst_tab [7] = '{sscc_pkg::RST_H_SEL, sscc_pkg::RST_H_WIDTH,
    sscc_pkg::RST_V_SEL, sscc_pkg::RST_V_WIDTH, sscc_pkg::RST_COAST_LEAD,
    sscc_pkg::RST_COAST_TRL, sscc_pkg::RST_COAST_SEL};

  always #25 aclk = ~aclk;

  sscc_video_src #(.LINE(LINE), .HW(4), .LINES(LINES), .VW(VW)) src (
    .aclk(aclk), .h_pol(h_pol), .v_pol(v_pol), .coast_lvl(coast_lvl),
    .hsync_pin(hs), .green_embedded_sync(gs), .vsync_pin(vs),
    .sep_vsync(sv), .coast_pin(cp), .pll_feedback(fb));

  // Short activity limit keeps source-loss detection inside the run
  sscc_top #(.ACT_LIMIT(1024)) DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hsync_pin(hs), .green_embedded_sync(gs),
    .vsync_pin(vs), .sep_vsync(sv), .coast_pin(cp), .pll_feedback(fb),
    .hsync_out(hsync_out), .vsync_out(vsync_out), .pll_coast(pll_coast));

  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where the inputs
  // launched at the last rising edge and the combinational readies settle
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] rb;
    // One idle edge keeps the last release and the new request apart
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      rb = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    chk(rb, er, "write response");
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    logic ha, hb;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hb = rvalid;
      v = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hb) rready <= 1'b0;
    end
  endtask

  // Settle two frames, then count active cycles over the next n cycles
  task cnt(input int n);
    repeat (2 * FRAME) @(posedge aclk);
    nh = 0;
    nv = 0;
    nc = 0;
    repeat (n) begin
      @(negedge aclk);
      nh += (hsync_out === 1'b1);
      nv += (vsync_out === 1'b1);
      nc += (pll_coast === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * (18 + i)), d, r);
      chk(d, {24'h0, rst_tab[i]}, "reset value");
    end
    wr(8'h4C, 32'hFFFF_FFA5, sscc_pkg::RESP_OKAY);
    rd(8'h4C, d, r);
    chk(d, 32'h0000_00A5, "width readback");
    wstrb <= 4'hE;
    wr(8'h4C, 32'h0000_0077, sscc_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h4C, d, r);
    chk(d, 32'h0000_00A5, "masked write");
    wr(8'hC0, 32'h0000_0011, sscc_pkg::RESP_SLVERR);
    rd(8'hC0, d, r);
    chk(32'(r), 32'(sscc_pkg::RESP_SLVERR), "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    $display("test registers done");
    wr(8'h4C, 32'h0, sscc_pkg::RESP_OKAY);
    cnt(4 * LINE);
    chk(nh, 0, "hsync idle high pol");
    wr(8'h48, 32'h10, sscc_pkg::RESP_OKAY);
    cnt(4 * LINE);
    chk(nh, 4 * LINE, "hsync idle low pol");
    wr(8'h4C, 32'h05, sscc_pkg::RESP_OKAY);
    cnt(4 * LINE);
    chk(nh, 4 * (LINE - 5), "hsync pulse low pol");
    wr(8'h48, 32'h18, sscc_pkg::RESP_OKAY);
    cnt(4 * LINE);
    chk(nh, 20, "hsync pulse width");
    $display("test hsync done");
    cnt(FRAME);
    chk(nv, VW * LINE, "vsync default");
    chk(nc, VW * LINE, "internal coast");
    wr(8'h50, 32'h10, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nv, FRAME - VW * LINE, "vsync negative out");
    wr(8'h50, 32'h28, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nv, FRAME - VW * LINE, "vsync user low");
    wr(8'h50, 32'h38, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nv, VW * LINE, "vsync user high");
    v_pol <= 1'b0;
    wr(8'h50, 32'h18, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nv, VW * LINE, "vsync auto low");
    v_pol <= 1'b1;
    wr(8'h54, 32'h03, sscc_pkg::RESP_OKAY);
    wr(8'h50, 32'h1E, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nv, 3 * LINE, "vsync duration");
    wr(8'h50, 32'h18, sscc_pkg::RESP_OKAY);
    $display("test vsync done");
    wr(8'h5C, 32'h02, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nc, (VW + 2) * LINE, "coast trail");
    wr(8'h58, 32'h01, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nc, (VW + 3) * LINE, "coast lead");
    wr(8'h60, 32'hC0, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nc, FRAME, "coast pin negative");
    coast_lvl <= 1'b1;
    wr(8'h60, 32'hE0, sscc_pkg::RESP_OKAY);
    cnt(FRAME);
    chk(nc, FRAME, "coast pin positive");
    $display("test coast done");
    cnt(1);
    rd(8'h7C, d, r);
    chk(d & 32'h1B, 32'h03, "detected high");
    h_pol <= 1'b0;
    v_pol <= 1'b0;
    // Detection needs the pins selected, so learn before switching away
    cnt(1);
    rd(8'h7C, d, r);
    chk(d & 32'h1B, 32'h00, "detected low");
    wr(8'h48, 32'hD8, sscc_pkg::RESP_OKAY);
    wr(8'h50, 32'hD8, sscc_pkg::RESP_OKAY);
    rd(8'h7C, d, r);
    chk(d & 32'h1B, 32'h18, "detected low, user sources");
    $display("test status done");
    wrap_up();
  end
endmodule
